// ==== hw/dcw_channel.sv ====
// Behaviour
// - bits 31:30 give destination step or fixed
// - bits 29:28 give destination access width
// - bits 27:26 give source step or fixed
// - bits 25:24 give source access width
// - bits 17:14 set interval two-to-R transfers
// - codes 1010 to 1111 never re-arbitrate
// - after interval, yield to higher priority request
// - count field plus one transfers performed
// - bit 3 set sets burst-only flag
// - bit 3 acts only at peripheral alternate end
// - clear burst flag when remainder below interval
// - mode 000 marks structure invalid, halts
// - modes 001 to 101 select channel mode
// - 110/111 peripheral scatter/gather primary/alternate
// - start addresses from end pointers minus count times step
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module dcw_channel
	import dcw_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	// register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata_q,
	// requests from the arbiter side
	input  wire logic        chan_req,
	input  wire logic        hi_req,
	// transfer issue
	output logic             xfer_q,
	output logic      [31:0] xfer_src_q,
	output logic      [31:0] xfer_dst_q,
	output logic      [1:0]  xfer_size_q,
	output logic             arb_q,
	output logic             done_q,
	// channel status
	output logic             busy_q,
	output logic             err_q,
	output logic             useburst_q,
	output logic      [2:0]  mode_q
);
	logic [31:0] ctrl_q;
	logic [31:0] src_end_q;
	logic [31:0] dst_end_q;
	logic [31:0] src_cur_q;
	logic [31:0] dst_cur_q;
	logic [10:0] remain_q;
	logic [9:0]  blk_q;
	logic [1:0]  src_code_q;
	logic [1:0]  dst_code_q;
	logic [3:0]  rpow_q;
	logic        nburst_q;
	logic [1:0]  size_q;
	dcw_state_t  state_q;

	// decoded fields of the stored word
	logic [1:0] w_dinc;
	logic [1:0] w_dsize;
	logic [1:0] w_sinc;
	logic [1:0] w_ssize;
	logic [9:0] w_cnt;
	dcw_mode_t  w_mode;
	assign w_dinc  = ctrl_q[DST_INC_LSB +: 2];
	assign w_dsize = ctrl_q[DST_SIZE_LSB +: 2];
	assign w_sinc  = ctrl_q[SRC_INC_LSB +: 2];
	assign w_ssize = ctrl_q[SRC_SIZE_LSB +: 2];
	assign w_cnt   = ctrl_q[CNT_LSB +: 10];
	assign w_mode  = dcw_mode_t'(ctrl_q[MODE_LSB +: 3]);

	function automatic logic [31:0] step_of(input logic [1:0] code);
		step_of = (code == INC_FIXED) ? 32'h0000_0000 : (32'h0000_0001 << code);
	endfunction : step_of

	// start = end - count * step; count field equals transfers minus one
	function automatic logic [31:0] start_of(input logic [31:0] ep, input logic [1:0] code, input logic [9:0] n);
		logic [31:0] span;
		span = 32'h0000_0000;
		if (code != INC_FIXED)
			span = {22'h000000, n} << code;
		start_of = ep - span;
	endfunction : start_of

	logic cmd_wr;
	logic start_go;
	logic cfg_bad;
	logic word_invalid;
	logic start_ok;
	assign cmd_wr       = wr && (addr == OFS_CMD);
	assign start_go     = cmd_wr && wdata[CMD_START] && (state_q == ST_IDLE);
	assign word_invalid = (w_mode == MODE_INVALID);
	assign cfg_bad      = (w_ssize == SIZE_RSVD) || (w_dsize == SIZE_RSVD);
	assign start_ok     = start_go && !word_invalid && !cfg_bad;

	// interval length minus one; codes above nine disable arbitration
	logic       arb_on;
	logic [9:0] blk_m1;
	assign arb_on = (rpow_q <= RPOW_MAX);
	assign blk_m1 = arb_on ? ~(10'h3FF << rpow_q) : 10'h3FF;

	logic go_xfer;
	logic last_xfer;
	logic blk_end;
	assign go_xfer   = (state_q == ST_RUN) && (chan_req || (mode_q == MODE_AUTO));
	assign last_xfer = (remain_q == 11'h001);
	assign blk_end   = arb_on && (blk_q == blk_m1);

	// remainder after this block below the interval
	logic [10:0] remain_after;
	logic [10:0] blk_len;
	logic        short_tail;
	assign remain_after = remain_q - 11'h001;
	assign blk_len      = {1'b0, blk_m1} + 11'h001;
	assign short_tail   = go_xfer && blk_end && !last_xfer && (remain_after < blk_len);

	// control word; a finished task marks its word spent so it cannot rerun
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			ctrl_q <= CTRL_RST;
		else if (ce) begin
			if (wr && addr == OFS_CTRL)
				ctrl_q <= wdata;
			else if (go_xfer && last_xfer)
				ctrl_q[MODE_LSB +: 3] <= MODE_INVALID;
		end
	end

	// end pointers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			src_end_q <= ADDR_RST;
		else if (ce && wr && addr == OFS_SRCEND)
			src_end_q <= wdata;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			dst_end_q <= ADDR_RST;
		else if (ce && wr && addr == OFS_DSTEND)
			dst_end_q <= wdata;
	end

	// channel state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
			busy_q  <= 1'b0;
		end else if (ce) begin
			unique case (state_q)
				ST_IDLE: begin
					if (start_go && !word_invalid && !cfg_bad) begin
						state_q <= ST_RUN;
						busy_q  <= 1'b1;
					end
				end
				ST_RUN: begin
					if (go_xfer && last_xfer) begin
						state_q <= ST_IDLE;
						busy_q  <= 1'b0;
					end else if (go_xfer && blk_end && hi_req) begin
						state_q <= ST_PAUSE;
					end
				end
				ST_PAUSE: begin
					if (!hi_req)
						state_q <= ST_RUN;
				end
				default: begin
					state_q <= ST_IDLE;
					busy_q  <= 1'b0;
				end
			endcase
		end
	end

	// address walk; start is the end pointer minus the task span
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			src_cur_q <= ADDR_RST;
			dst_cur_q <= ADDR_RST;
		end else if (ce) begin
			if (start_ok) begin
				src_cur_q <= start_of(src_end_q, w_sinc, w_cnt);
				dst_cur_q <= start_of(dst_end_q, w_dinc, w_cnt);
			end else if (go_xfer) begin
				src_cur_q <= src_cur_q + step_of(src_code_q);
				dst_cur_q <= dst_cur_q + step_of(dst_code_q);
			end
		end
	end

	// transfers left and position inside the arbitration block
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			remain_q <= 11'h000;
			blk_q    <= 10'h000;
		end else if (ce) begin
			if (start_ok) begin
				remain_q <= {1'b0, w_cnt} + 11'h001;
				blk_q    <= 10'h000;
			end else if (go_xfer) begin
				remain_q <= remain_after;
				blk_q    <= blk_end ? 10'h000 : blk_q + 10'h001;
			end
		end
	end

	// fields held for the whole task; a rewrite of the word mid-task cannot disturb it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			src_code_q <= 2'h0;
			dst_code_q <= 2'h0;
			size_q     <= 2'h0;
			rpow_q     <= 4'h0;
			nburst_q   <= 1'b0;
			mode_q     <= MODE_INVALID;
		end else if (ce && start_ok) begin
			src_code_q <= w_sinc;
			dst_code_q <= w_dinc;
			size_q     <= w_ssize;
			rpow_q     <= ctrl_q[RPOW_LSB +: 4];
			nburst_q   <= ctrl_q[NBURST_BIT];
			mode_q     <= w_mode;
		end
	end

	// one-cycle event pulses
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			xfer_q <= 1'b0;
			arb_q  <= 1'b0;
			done_q <= 1'b0;
		end else if (ce) begin
			xfer_q <= go_xfer;
			arb_q  <= go_xfer && blk_end && !last_xfer;
			done_q <= go_xfer && last_xfer;
		end
	end

	// issued address and width, held until the next transfer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			xfer_src_q  <= ADDR_RST;
			xfer_dst_q  <= ADDR_RST;
			xfer_size_q <= 2'h0;
		end else if (ce && go_xfer) begin
			xfer_src_q  <= src_cur_q;
			xfer_dst_q  <= dst_cur_q;
			xfer_size_q <= size_q;
		end
	end

	// burst-only flag; hardware set beats any clear
	logic burst_hw_set;
	assign burst_hw_set = go_xfer && last_xfer && (mode_q == MODE_PSG_ALT) && nburst_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			useburst_q <= 1'b0;
		else if (ce) begin
			if (burst_hw_set || (cmd_wr && wdata[CMD_BURST_SET]))
				useburst_q <= 1'b1;
			else if (short_tail || (cmd_wr && wdata[CMD_BURST_CLR]))
				useburst_q <= 1'b0;
		end
	end

	// configuration error; a start with a bad word wins over a clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			err_q <= 1'b0;
		else if (ce) begin
			if (start_go && !word_invalid && cfg_bad)
				err_q <= 1'b1;
			else if (cmd_wr && wdata[CMD_ERR_CLR])
				err_q <= 1'b0;
		end
	end

	// read port, data one cycle after the strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rdata_q <= 32'h0000_0000;
		else if (ce) begin
			rdata_q <= 32'h0000_0000;
			if (rd) begin
				unique case (addr)
					OFS_CTRL:   rdata_q <= ctrl_q;
					OFS_SRCEND: rdata_q <= src_end_q;
					OFS_DSTEND: rdata_q <= dst_end_q;
					OFS_STAT:   rdata_q <= {24'h000000, mode_q, state_q == ST_PAUSE, useburst_q, err_q, busy_q, 1'b0};
					OFS_SRCCUR: rdata_q <= src_cur_q;
					OFS_DSTCUR: rdata_q <= dst_cur_q;
					OFS_REMAIN: rdata_q <= {21'h000000, remain_q};
					default:    rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule : dcw_channel

// ==== hw/dcw_pkg.sv ====
package dcw_pkg;
	// control word fields
	localparam int DST_INC_LSB  = 30;
	localparam int DST_SIZE_LSB = 28;
	localparam int SRC_INC_LSB  = 26;
	localparam int SRC_SIZE_LSB = 24;
	localparam int RSV_LSB      = 18;
	localparam int RPOW_LSB     = 14;
	localparam int CNT_LSB      = 4;
	localparam int NBURST_BIT   = 3;
	localparam int MODE_LSB     = 0;
	localparam logic [1:0] INC_FIXED  = 2'h3;
	localparam logic [1:0] SIZE_RSVD  = 2'h3;
	localparam logic [3:0] RPOW_MAX   = 4'h9;
	// register offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_SRCEND = 8'h04;
	localparam logic [7:0] OFS_DSTEND = 8'h08;
	localparam logic [7:0] OFS_CMD    = 8'h0C;
	localparam logic [7:0] OFS_STAT   = 8'h10;
	localparam logic [7:0] OFS_SRCCUR = 8'h14;
	localparam logic [7:0] OFS_DSTCUR = 8'h18;
	localparam logic [7:0] OFS_REMAIN = 8'h1C;
	// command bits
	localparam int CMD_START     = 0;
	localparam int CMD_BURST_SET = 1;
	localparam int CMD_BURST_CLR = 2;
	localparam int CMD_ERR_CLR   = 3;
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] ADDR_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		MODE_INVALID  = 3'b000,
		MODE_BASIC    = 3'b001,
		MODE_AUTO     = 3'b010,
		MODE_PINGPONG = 3'b011,
		MODE_MSG_PRI  = 3'b100,
		MODE_MSG_ALT  = 3'b101,
		MODE_PSG_PRI  = 3'b110,
		MODE_PSG_ALT  = 3'b111
	} dcw_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_RUN   = 2'b01,
		ST_PAUSE = 2'b10
	} dcw_state_t;
endpackage : dcw_pkg

// ==== testbench/dcw_arb_peer.sv ====
`timescale 1ns/10ps
module dcw_arb_peer (
	// control from bench
	input wire logic clk,
	input wire logic req_en,
	input wire logic hi_en,
	// to channel
	output logic     chan_req,
	output logic     hi_req
);
	logic [2:0] cnt_q = 3'h0;
	// higher channel pending four cycles of eight
	always_ff @(posedge clk)
		cnt_q <= cnt_q + 3'h1;
	assign hi_req = hi_en && cnt_q[2];
	assign chan_req = req_en;
endmodule : dcw_arb_peer

// ==== testbench/dcw_channel_props.sv ====
`timescale 1ns/10ps
module dcw_channel_chk
	import dcw_pkg::*;
(
	// watched ports
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic [7:0] addr,
	input wire logic       wr,
	input wire logic       hi_req,
	input wire logic       xfer_q,
	input wire logic       arb_q,
	input wire logic       done_q,
	input wire logic       busy_q,
	input wire logic       err_q,
	input wire logic [2:0] mode_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_done_xfer; done_q |-> xfer_q && !arb_q; endproperty
	a_done_xfer: assert property (p_done_xfer) else $error("done without last transfer");
	property p_done_idle; done_q |=> !busy_q; endproperty
	a_done_idle: assert property (p_done_idle) else $error("busy after done");
	property p_arb_xfer; arb_q |-> xfer_q && busy_q; endproperty
	a_arb_xfer: assert property (p_arb_xfer) else $error("arbitration off a transfer");
	property p_pause; arb_q && $past(hi_req) |=> !xfer_q; endproperty
	a_pause: assert property (p_pause) else $error("no yield to higher request");
	property p_start; $rose(busy_q) |-> $past(wr) && $past(addr) == OFS_CMD; endproperty
	a_start: assert property (p_start) else $error("task began without start");
	property p_mode; $rose(busy_q) |-> mode_q != MODE_INVALID; endproperty
	a_mode: assert property (p_mode) else $error("task runs in invalid mode");
	property p_err; $rose(err_q) |-> !busy_q && $past(wr) && $past(addr) == OFS_CMD; endproperty
	a_err: assert property (p_err) else $error("error without refused start");
	property p_xfer_busy; xfer_q && !done_q |-> busy_q; endproperty
	a_xfer_busy: assert property (p_xfer_busy) else $error("transfer while idle");
endmodule : dcw_channel_chk

// ==== testbench/testbench.sv ====
`timescale 1ns/10ps
module testbench
	import dcw_pkg::*;
;
	logic        clk, arst_n, wr, rd, req_en, hi_en, xfer_q, arb_q, done_q, busy_q, err_q, useb, chan_req, hi_req;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata_q, xsrc, xdst, fs, fd, ls;
	logic [1:0]  xsz, sz;
	logic [2:0]  mode_q, lm;
	int          mismatches, checks_done, nx, na, st;
	dcw_channel dcw_channel_i (.clk, .arst_n, .ce(1'b1), .addr, .wdata, .wr, .rd, .rdata_q, .chan_req, .hi_req,
		.xfer_q, .xfer_src_q(xsrc), .xfer_dst_q(xdst), .xfer_size_q(xsz), .arb_q, .done_q, .busy_q, .err_q,
		.useburst_q(useb), .mode_q);
	dcw_arb_peer dcw_arb_peer_i (.clk, .req_en, .hi_en, .chan_req, .hi_req);
	task finish_test;
		if (mismatches == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task rchk(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(n, e, rdata_q);
	endtask : rchk
	// zero reserved field, equal widths, same step code for source and destination
	function logic [31:0] cw(input logic [1:0] i, input logic [1:0] s, input logic [3:0] r,
		input logic [9:0] n, input logic b, input logic [2:0] m);
		return {i, s, i, s, 6'h00, r, n, b, m};
	endfunction : cw
	task run(input logic [31:0] w);
		wreg(OFS_CTRL, w);
		wreg(OFS_CMD, 32'h1);
		nx = 0;
		na = 0;
		for (int i = 0; i < 3000 && done_q !== 1'b1; i++) begin
			@(posedge clk) #1;
			if (arb_q === 1'b1)
				na++;
			if (xfer_q === 1'b1) begin
				if (nx == 0)
					{fs, fd, lm} = {xsrc, xdst, mode_q};
				nx++;
				{ls, sz} = {xsrc, xsz};
			end
		end
		if (done_q !== 1'b1) begin
			mismatches++;
			finish_test();
		end
		@(posedge clk) #1;
	endtask : run
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{arst_n, wr, rd, addr, wdata, req_en, hi_en, mismatches, checks_done} = '0;
		req_en = 1'b1;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		rchk(OFS_CTRL, CTRL_RST, "ctrl reset");
		rchk(OFS_SRCEND, ADDR_RST, "src end reset");
		rchk(8'h40, 32'h0, "unmapped");
		wreg(OFS_SRCEND, 32'h100);
		wreg(OFS_DSTEND, 32'h200);
		for (int k = 0; k < 4; k++) begin
			st = k == 3 ? 0 : 1 << k;
			run(cw(2'(k), k == 3 ? 2'h2 : 2'(k), 4'h0, 10'h3, 1'b0, MODE_BASIC));
			chk("count", 4, nx);
			chk("src first", 32'h100 - 3 * st, fs);
			chk("dst first", 32'h200 - 3 * st, fd);
			chk("src last", 32'h100, ls);
			chk("size", k == 3 ? 2 : k, sz);
			chk("arb every", 3, na);
		end
		rchk(OFS_CTRL, cw(2'h3, 2'h2, 4'h0, 10'h3, 1'b0, MODE_INVALID), "ctrl after end");
		for (int m = 1; m < 8; m++) begin
			wreg(OFS_CMD, 32'h4);
			req_en <= m != 2;
			run(cw(2'h1, 2'h1, 4'hA + 4'(m % 6), 10'h1, 1'b1, 3'(m)));
			chk("mode", m, lm);
			chk("arb none", 0, na);
			chk("burst", m == 7, useb);
		end
		wreg(OFS_CMD, 32'h2);
		req_en <= 1'b1;
		hi_en <= 1'b1;
		run(cw(2'h2, 2'h2, 4'h1, 10'h5, 1'b0, MODE_BASIC));
		chk("arb two", 2, na);
		chk("burst kept", 1, useb);
		run(cw(2'h2, 2'h2, 4'h1, 10'h4, 1'b0, MODE_BASIC));
		chk("count five", 5, nx);
		chk("burst cleared", 0, useb);
		wreg(OFS_CTRL, cw(2'h2, 2'h3, 4'h0, 10'h0, 1'b0, MODE_BASIC));
		hi_en <= 1'b0;
		wreg(OFS_CMD, 32'h1);
		@(posedge clk) #1 chk("err", 1, err_q);
		chk("busy err", 0, busy_q);
		rchk(OFS_STAT, 32'h24, "stat err");
		wreg(OFS_CMD, 32'h8);
		@(posedge clk) #1 chk("err clear", 0, err_q);
		wreg(OFS_CTRL, cw(2'h2, 2'h2, 4'h0, 10'h0, 1'b0, MODE_INVALID));
		wreg(OFS_CMD, 32'h1);
		@(posedge clk) #1 chk("busy invalid", 0, busy_q);
		chk("err invalid", 0, err_q);
		rchk(OFS_CMD, 32'h0, "cmd read");
		finish_test();
	end
endmodule : testbench
bind dcw_channel dcw_channel_chk dcw_channel_chk_i (.clk, .arst_n, .addr, .wr, .hi_req, .xfer_q, .arb_q,
	.done_q, .busy_q, .err_q, .mode_q);
